// *** verilog/msp_pkg.sv ***
// Shared constants and types for the second motion state program.
// Assumes byte-wide register access and one clock for all logic.
package msp_pkg;
	localparam int DW = 8;
	typedef struct packed {
		logic [7:0] x;
		logic [7:0] y;
		logic [7:0] z;
		logic [7:0] v;
	} msp_sample_t;
	typedef struct packed {
		logic peak_detect_enable;
		logic third_limit_swapmask_reset;
		logic signed_threshold_select;
		logic difference_data_select;
		logic shift_select;
		logic third_limit_defaultmask_reset;
		logic temp_mask_release;
		logic output_on_stop_continue;
	} msp_sett_t;
	typedef enum logic {MSP_HALT, MSP_RUN} msp_state_t;
	localparam logic [3:0] ADDR_STEP_PAGE = 4'h6;
	localparam logic [7:0] ADDR_TIM4 = 8'h70;
	localparam logic [7:0] ADDR_TIM3 = 8'h71;
	localparam logic [7:0] ADDR_TIM2_L = 8'h72;
	localparam logic [7:0] ADDR_TIM2_H = 8'h73;
	localparam logic [7:0] ADDR_TIM1_L = 8'h74;
	localparam logic [7:0] ADDR_TIM1_H = 8'h75;
	localparam logic [7:0] ADDR_THR2 = 8'h76;
	localparam logic [7:0] ADDR_THR1 = 8'h77;
	localparam logic [7:0] ADDR_SWAP = 8'h79;
	localparam logic [7:0] ADDR_DMASK = 8'h7a;
	localparam logic [7:0] ADDR_SETT = 8'h7b;
	localparam logic [7:0] ADDR_PTRS = 8'h7c;
	localparam logic [7:0] ADDR_TC_L = 8'h7d;
	localparam logic [7:0] ADDR_TC_H = 8'h7e;
	localparam logic [7:0] ADDR_OUTS = 8'h7f;
	localparam logic [3:0] C_NOP = 4'h0;
	localparam logic [3:0] C_TI1 = 4'h1;
	localparam logic [3:0] C_TI2 = 4'h2;
	localparam logic [3:0] C_TI3 = 4'h3;
	localparam logic [3:0] C_TI4 = 4'h4;
	localparam logic [3:0] C_GN1 = 4'h5;
	localparam logic [3:0] C_GN2 = 4'h6;
	localparam logic [3:0] C_LN1 = 4'h7;
	localparam logic [3:0] C_LN2 = 4'h8;
	localparam logic [3:0] C_GT1 = 4'h9;
	localparam logic [3:0] C_LL2 = 4'ha;
	localparam logic [3:0] C_GR1 = 4'hb;
	localparam logic [3:0] C_LR1 = 4'hc;
	localparam logic [3:0] C_GR2 = 4'hd;
	localparam logic [3:0] C_LR2 = 4'he;
	localparam logic [3:0] C_ZC = 4'hf;
	localparam logic [7:0] CMD_STOP = 8'h00;
	localparam logic [7:0] CMD_CONT = 8'h11;
	localparam logic [7:0] CMD_SET_OUTPUTS_COMMAND = 8'h88;
	localparam logic [7:0] CMD_CHOOSE_DEFAULT_MASK_CMD = 8'h14;
	localparam logic [7:0] CMD_CHOOSE_SWAP_MASK_CMD = 8'h24;
	localparam logic [7:0] SETT_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [7:0] TMASK_DEF = 8'hff;
	localparam logic [15:0] TIM_RST = 16'h0000;
endpackage

// *** verilog/msp_axis_cmp.sv ***
// One axis compared against one limit, both directions.
// Assumes value and limit are two's complement of equal width.
`timescale 1ns/1ps
module msp_axis_cmp #(
	parameter int W = 8
) (
	// Operands
	input wire logic [W-1:0] value,
	input wire logic [W-1:0] limit,
	input wire logic signed_mode,
	// Results
	output logic pos_gt,
	output logic neg_gt
);
	logic signed [W:0] v;
	logic signed [W:0] l;
	logic signed [W:0] mag;
	always_comb begin
		v = {value[W-1], value};
		l = {limit[W-1], limit};
		mag = l[W] ? -l : l;
		if (signed_mode) begin
			// A positive limit watches the plus side, a negative one the minus.
			pos_gt = !l[W] && (v > l);
			neg_gt = l[W] && (v < l);
		end else begin
			pos_gt = v > mag;
			neg_gt = -v > mag;
		end
	end
endmodule

// *** verilog/msp_step_mem.sv ***
// Sixteen program step bytes with a registered read port.
// Assumes the read address is held at least one cycle before use.
`timescale 1ns/1ps
module msp_step_mem #(
	parameter int AW = 4,
	parameter int DW = 8
) (
	// Clock
	input wire logic clock,
	// Write side
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [DW-1:0] wr_data,
	// Read side
	input wire logic [AW-1:0] rd_addr,
	output logic [DW-1:0] rd_data_q
);
	logic [DW-1:0] mem [2**AW];
	always_ff @(posedge clock) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data_q <= mem[rd_addr];
	end
endmodule

// *** verilog/msp_top.sv ***
// Control, status and condition decoding of the second state program.
// Assumes a byte register port behind the serial interface and samples
// that arrive at least two clocks apart.
// Operation
// (RULE_01) Flow bit seven enables peak detection.
// (RULE_02) Swap-mask third-limit bit resets on overflow.
// (RULE_03) Third-limit test ignores temporary axis mask.
// (RULE_04) One third limit shared by both programs.
// (RULE_05) Default-mask third-limit bit resets on overflow.
// (RULE_06) Signed bit chooses symmetric or signed limits.
// (RULE_07) Difference bit chooses raw or difference data.
// (RULE_08) Shift bit chooses second difference or shift.
// (RULE_09) Release bit restores temporary mask after next.
// (RULE_10) Stop and continue also output when enabled.
// (RULE_11) Pointer register: program low, reset high.
// (RULE_12) Timer count readable as low, high bytes.
// (RULE_13) Reading output flags releases interrupt, clears.
// (RULE_14) No-operation code passes straight to conditions.
// (RULE_15) Timer codes valid on expiry, no data.
// (RULE_16) Above-limit codes trigger on first exceeding axis.
// (RULE_17) At-or-below codes trigger on first axis.
// (RULE_18) All-axes code needs every axis below two.
// (RULE_19) Reversed codes compare against negated limits.
// (RULE_20) Zero-cross code triggers on sign change.
// (RULE_21) Mask commands select default or swap mask.
// (RULE_22) Set mask bit enables that axis direction.
// (RULE_23) One evaluation per sample, advance when valid.
// (RULE_24) Step byte: reset nibble high, next low.
`timescale 1ns/1ps
module msp_top import msp_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata_q,
	// Samples and shared limit
	input wire logic sample_valid,
	input wire msp_sample_t sample,
	input wire msp_sample_t shift_ref,
	input wire logic [7:0] shared_third_limit,
	// Commands
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	// Status
	output logic irq_q,
	output logic running_q
);
	msp_sett_t sett_q, sett_d;
	logic [7:0] swap_q, swap_d, dmask_q, dmask_d;
	logic [7:0] thr1_q, thr1_d, thr2_q, thr2_d, rdata_d;
	logic [3:0][15:0] tim_q, tim_d;
	msp_state_t st_q, st_d;
	logic [3:0] pp_q, pp_d, rp_q, rp_d;
	logic [15:0] tc_q, tc_d;
	logic mp_q, mp_d, peak_q, peak_d, irq_d;
	logic [7:0] tmask_q, tmask_d, trig_q, trig_d, outs_q, outs_d;
	msp_sample_t h1_q, h1_d, h2_q, h2_d, pv_q, pv_d;
	logic [7:0] step_q, emask, zc, nhit, rhit;
	logic [3:0][7:0] sv, h1v, h2v, shv, pvv, ev;
	logic [4:0][7:0] thv, gt;
	logic [3:0] tok;
	logic nxt_ok, rst_ok, t3_hit, out_ev, step_we;

	function automatic logic [7:0] first_dir(input logic [7:0] h);
		logic [7:0] r;
		r = '0;
		for (int i = 0; i < 8; i++) begin
			if (h[i]) begin
				r = 8'h01 << i;
			end
		end
		return r;
	endfunction

	function automatic logic [8:0] cond_eval(input logic [3:0] c,
		input logic [4:0][7:0] g, input logic [7:0] m,
		input logic [3:0] t, input logic [7:0] z);
		logic [7:0] h;
		logic ok;
		h = '0;
		ok = 1'b0;
		case (c)
			C_NOP: ok = 1'b1; // RULE_14
			C_TI1: ok = t[0]; // RULE_15
			C_TI2: ok = t[1]; // RULE_15
			C_TI3: ok = t[2]; // RULE_15
			C_TI4: ok = t[3]; // RULE_15
			C_GN1, C_GT1: h = m & g[0]; // RULE_16
			C_GN2: h = m & g[1]; // RULE_16
			C_LN1: h = m & ~g[0]; // RULE_17
			C_LN2: h = m & ~g[1]; // RULE_17
			C_LL2: begin
				ok = (m != '0) && ((m & g[1]) == '0); // RULE_18
				h = ok ? m : '0;
			end
			C_GR1: h = m & g[2]; // RULE_19
			C_LR1: h = m & ~g[2]; // RULE_19
			C_GR2: h = m & g[3]; // RULE_19
			C_LR2: h = m & ~g[3]; // RULE_19
			C_ZC: h = m & z; // RULE_20
			default: ok = 1'b0;
		endcase
		return {ok || (h != '0), h};
	endfunction

	assign sv = sample;
	assign h1v = h1_q;
	assign h2v = h2_q;
	assign shv = shift_ref;
	assign pvv = pv_q;
	// Negated limits wrap at the most negative code; keep limits inside it.
	assign thv = {shared_third_limit, -thr2_q, -thr1_q, thr2_q, thr1_q};

	genvar a, t;
	generate
		for (a = 0; a < 4; a++) begin : g_axis
			logic signed [9:0] d2, cs;
			assign d2 = {{2{sv[a][7]}}, sv[a]} - {h1v[a][7], h1v[a], 1'b0}
				+ {{2{h2v[a][7]}}, h2v[a]};
			assign cs = {{2{sv[a][7]}}, sv[a]} - {{2{shv[a][7]}}, shv[a]};
			assign ev[a] = !sett_q.difference_data_select ? sv[a] : // RULE_07
				(sett_q.shift_select ? cs[7:0] : d2[7:0]); // RULE_08
			assign zc[2*a+1] = pvv[a][7] && !ev[a][7]; // RULE_20
			assign zc[2*a] = !pvv[a][7] && ev[a][7]; // RULE_20
			for (t = 0; t < 5; t++) begin : g_lim
				msp_axis_cmp #(.W(DW)) u_cmp (
					.value(ev[a]),
					.limit(thv[t]),
					.signed_mode(t == 4 ? 1'b0 :
						sett_q.signed_threshold_select), // RULE_06
					.pos_gt(gt[t][2*a+1]),
					.neg_gt(gt[t][2*a])
				);
			end
		end
	endgenerate

	assign step_we = reg_wr && (reg_addr[7:4] == ADDR_STEP_PAGE);
	msp_step_mem #(.AW(4), .DW(8)) u_mem (
		.clock(clock),
		.wr_en(step_we),
		.wr_addr(reg_addr[3:0]),
		.wr_data(reg_wdata),
		.rd_addr(pp_q),
		.rd_data_q(step_q)
	);

	always_comb begin
		emask = (mp_q ? swap_q : dmask_q) & tmask_q; // RULE_22
		for (int i = 0; i < 4; i++) begin
			tok[i] = tc_q >= tim_q[i];
		end
		{rst_ok, rhit} = cond_eval(step_q[7:4], gt, emask, tok, zc); // RULE_24
		{nxt_ok, nhit} = cond_eval(step_q[3:0], gt, emask, tok, zc); // RULE_24
		// The third limit sees all directions, whatever the masks say.
		t3_hit = (gt[4] != '0) && ((sett_q.third_limit_swapmask_reset && mp_q)
			|| (sett_q.third_limit_defaultmask_reset && !mp_q)); // RULE_02 RULE_03 RULE_04 RULE_05
	end

	// Host side registers.
	always_comb begin
		sett_d = sett_q;
		swap_d = swap_q;
		dmask_d = dmask_q;
		thr1_d = thr1_q;
		thr2_d = thr2_q;
		tim_d = tim_q;
		rdata_d = reg_rdata_q;
		if (reg_wr) begin
			case (reg_addr)
				ADDR_SETT: sett_d = reg_wdata;
				ADDR_SWAP: swap_d = reg_wdata;
				ADDR_DMASK: dmask_d = reg_wdata;
				ADDR_THR1: thr1_d = reg_wdata;
				ADDR_THR2: thr2_d = reg_wdata;
				ADDR_TIM4: tim_d[3] = {8'h00, reg_wdata};
				ADDR_TIM3: tim_d[2] = {8'h00, reg_wdata};
				ADDR_TIM2_L: tim_d[1][7:0] = reg_wdata;
				ADDR_TIM2_H: tim_d[1][15:8] = reg_wdata;
				ADDR_TIM1_L: tim_d[0][7:0] = reg_wdata;
				ADDR_TIM1_H: tim_d[0][15:8] = reg_wdata;
				default: ;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				ADDR_PTRS: rdata_d = {rp_q, pp_q}; // RULE_11
				ADDR_TC_L: rdata_d = tc_q[7:0]; // RULE_12
				ADDR_TC_H: rdata_d = tc_q[15:8]; // RULE_12
				ADDR_OUTS: rdata_d = outs_q; // RULE_13
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			sett_q <= SETT_RST;
			swap_q <= MASK_RST;
			dmask_q <= MASK_RST;
			thr1_q <= 8'h00;
			thr2_q <= 8'h00;
			tim_q <= {4{TIM_RST}};
			reg_rdata_q <= 8'h00;
		end else begin
			sett_q <= sett_d;
			swap_q <= swap_d;
			dmask_q <= dmask_d;
			thr1_q <= thr1_d;
			thr2_q <= thr2_d;
			tim_q <= tim_d;
			reg_rdata_q <= rdata_d;
		end
	end

	// Program flow.
	always_comb begin
		st_d = st_q;
		pp_d = pp_q;
		rp_d = rp_q;
		tc_d = tc_q;
		mp_d = mp_q;
		tmask_d = tmask_q;
		trig_d = trig_q;
		peak_d = peak_q;
		h1_d = h1_q;
		h2_d = h2_q;
		pv_d = pv_q;
		out_ev = 1'b0;
		outs_d = outs_q;
		irq_d = irq_q;
		if (reg_rd && reg_addr == ADDR_OUTS) begin
			outs_d = 8'h00; // RULE_13
			irq_d = 1'b0; // RULE_13
		end
		if (cmd_valid) begin
			case (cmd_code)
				CMD_STOP: begin
					st_d = MSP_HALT;
					rp_d = '0;
					out_ev = sett_q.output_on_stop_continue; // RULE_10
				end
				CMD_CONT: begin
					st_d = MSP_RUN;
					pp_d = rp_q;
					out_ev = sett_q.output_on_stop_continue; // RULE_10
				end
				CMD_SET_OUTPUTS_COMMAND: out_ev = 1'b1;
				CMD_CHOOSE_DEFAULT_MASK_CMD: mp_d = 1'b0; // RULE_21
				CMD_CHOOSE_SWAP_MASK_CMD: mp_d = 1'b1; // RULE_21
				default: ;
			endcase
		end else if (sample_valid) begin
			h1_d = sample;
			h2_d = h1_q;
			pv_d = ev;
			case (st_q)
				MSP_RUN: begin
					tc_d = tc_q + 16'h0001;
					if (t3_hit || rst_ok) begin
						pp_d = rp_q; // RULE_02 RULE_05
						tc_d = '0;
						tmask_d = TMASK_DEF;
						peak_d = 1'b0;
						trig_d = first_dir(rhit);
					end else if (nxt_ok) begin
						pp_d = pp_q + 4'h1; // RULE_23
						tc_d = '0;
						if (nhit != '0) begin
							trig_d = first_dir(nhit); // RULE_16 RULE_17
						end
						if (sett_q.temp_mask_release) begin
							tmask_d = TMASK_DEF; // RULE_09
							peak_d = 1'b0; // RULE_09
						end else if (sett_q.peak_detect_enable
							&& nhit != '0) begin
							tmask_d = first_dir(nhit); // RULE_01
							peak_d = 1'b1; // RULE_01
						end
					end
				end
				default: ;
			endcase
		end
		if (!sett_q.peak_detect_enable) begin
			peak_d = 1'b0; // RULE_01
		end
		// A set in the same cycle as the clearing read wins.
		if (out_ev) begin
			outs_d = outs_q | trig_q;
			irq_d = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			st_q <= MSP_RUN;
			pp_q <= '0;
			rp_q <= '0;
			tc_q <= '0;
			mp_q <= 1'b0;
			tmask_q <= TMASK_DEF;
			trig_q <= '0;
			peak_q <= 1'b0;
			h1_q <= '0;
			h2_q <= '0;
			pv_q <= '0;
			outs_q <= '0;
			irq_q <= 1'b0;
			running_q <= 1'b1;
		end else begin
			st_q <= st_d;
			pp_q <= pp_d;
			rp_q <= rp_d;
			tc_q <= tc_d;
			mp_q <= mp_d;
			tmask_q <= tmask_d;
			trig_q <= trig_d;
			peak_q <= peak_d;
			h1_q <= h1_d;
			h2_q <= h2_d;
			pv_q <= pv_d;
			outs_q <= outs_d;
			irq_q <= irq_d;
			running_q <= st_d == MSP_RUN;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_eval;
		sample_valid && !cmd_valid && st_q == MSP_RUN;
	endsequence
	sequence s_next;
		s_eval ##0 (nxt_ok && !rst_ok && !t3_hit);
	endsequence

	property p_ptrs;
		reg_rd && reg_addr == ADDR_PTRS |=> reg_rdata_q == $past({rp_q, pp_q});
	endproperty
	a_ptrs: assert property (p_ptrs) else $error("pointer read wrong"); // RULE_11
	property p_tch;
		reg_rd && reg_addr == ADDR_TC_H |=> reg_rdata_q == $past(tc_q[15:8]);
	endproperty
	a_tch: assert property (p_tch) else $error("timer high read wrong"); // RULE_12
	property p_clear;
		reg_rd && reg_addr == ADDR_OUTS && !cmd_valid |=> outs_q == '0 && !irq_q;
	endproperty
	a_clear: assert property (p_clear) else $error("flags not cleared"); // RULE_13
	property p_next;
		s_next |=> pp_q == $past(pp_q) + 4'h1 && tc_q == '0;
	endproperty
	a_next: assert property (p_next) else $error("no advance"); // RULE_23
	property p_thr3;
		s_eval ##0 t3_hit |=> pp_q == $past(rp_q);
	endproperty
	a_thr3: assert property (p_thr3) else $error("no limit reset"); // RULE_02
	property p_nop;
		s_eval ##0 (step_q == {C_LN1, C_NOP} && (emask & ~gt[0]) == '0
			&& !t3_hit) |=> pp_q == $past(pp_q) + 4'h1;
	endproperty
	a_nop: assert property (p_nop) else $error("nop did not pass"); // RULE_14
	property p_sel;
		cmd_valid && cmd_code == CMD_CHOOSE_SWAP_MASK_CMD |=> mp_q ##1 1'b1;
	endproperty
	a_sel: assert property (p_sel) else $error("swap mask not chosen"); // RULE_21
	property p_stop;
		cmd_valid && cmd_code == CMD_STOP && sett_q.output_on_stop_continue
			|=> irq_q && !running_q && rp_q == '0;
	endproperty
	a_stop: assert property (p_stop) else $error("stop output missing"); // RULE_10
	property p_peak;
		!sett_q.peak_detect_enable ##1 !$past(sett_q.peak_detect_enable)
			|-> !peak_q;
	endproperty
	a_peak: assert property (p_peak) else $error("peak flag while off"); // RULE_01
	property p_rel;
		s_next ##0 sett_q.temp_mask_release |=> tmask_q == TMASK_DEF;
	endproperty
	a_rel: assert property (p_rel) else $error("mask not released"); // RULE_09
endmodule

// *** verif/msp_host_model.sv ***
// Host side of the register port, one byte per access.
// Assumes a clock on which the device samples at the rising edge.
`timescale 1ns/1ps
module msp_host_model (
	// Clock
	input wire logic clock,
	// Register port
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata_q
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end

	// Strobes change at the falling edge, so the device sees them settled.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clock);
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask

	// Data is taken half a cycle after the read edge, as the port registers it.
	// A read of the flag byte is also what frees the pending interrupt.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clock);
		reg_rd = 1'b0;
		d = reg_rdata_q;
	endtask
endmodule

// *** verif/tb_msp_top.sv ***
// Self-checking bench for the second state program block.
// Assumes the host model drives the register port and the bench the rest.
`timescale 1ns/1ps
module tb_msp_top import msp_pkg::*;;
	logic clock;
	logic rst;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata_q;
	logic sample_valid;
	msp_sample_t sample;
	msp_sample_t shift_ref;
	logic [7:0] shared_third_limit;
	logic cmd_valid;
	logic [7:0] cmd_code;
	logic irq_q;
	logic running_q;
	int num_errors;
	int check_count;
	logic [7:0] rv;

	msp_top dut_u (
		.clock(clock),
		.rst(rst),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata_q(reg_rdata_q),
		.sample_valid(sample_valid),
		.sample(sample),
		.shift_ref(shift_ref),
		.shared_third_limit(shared_third_limit),
		.cmd_valid(cmd_valid),
		.cmd_code(cmd_code),
		.irq_q(irq_q),
		.running_q(running_q)
	);

	msp_host_model host_u (
		.clock(clock),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata_q(reg_rdata_q)
	);

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		host_u.rd(a, rv);
		chk(rv, exp);
	endtask

	// Samples are spaced well beyond the two-cycle minimum.
	task automatic smp(input logic [7:0] x);
		@(negedge clock);
		sample = '{x: x, y: 8'h00, z: 8'h00, v: 8'h00};
		sample_valid = 1'b1;
		@(negedge clock);
		sample_valid = 1'b0;
		repeat (3) @(negedge clock);
	endtask

	task automatic cmd(input logic [7:0] c);
		@(negedge clock);
		cmd_code = c;
		cmd_valid = 1'b1;
		@(negedge clock);
		cmd_valid = 1'b0;
		@(negedge clock);
	endtask

	task automatic give_verdict();
		$display("checks=%0d errors=%0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		#200000;
		num_errors++;
		give_verdict();
	end

	initial begin
		num_errors = 0;
		check_count = 0;
		rst = 1'b1;
		sample_valid = 1'b0;
		sample = '0;
		shift_ref = '0;
		shared_third_limit = 8'h30;
		cmd_valid = 1'b0;
		cmd_code = 8'h00;
		repeat (6) @(negedge clock);
		rst = 1'b0;
		rdc(ADDR_PTRS, 8'h00);
		rdc(ADDR_TC_L, 8'h00);
		rdc(ADDR_TC_H, 8'h00);
		rdc(ADDR_OUTS, 8'h00);
		rdc(ADDR_SETT, 8'h00);
		chk({7'h00, running_q}, 8'h01);
		$display("test reset values done");
		// Every step resets above limit two and advances above limit one.
		for (int i = 0; i < 16; i++)
			host_u.wr({ADDR_STEP_PAGE, i[3:0]}, 8'h65);
		host_u.wr(ADDR_THR2, 8'h7f);
		host_u.wr(ADDR_THR1, 8'h10);
		host_u.wr(ADDR_SWAP, 8'hff);
		host_u.wr(ADDR_DMASK, 8'hff);
		host_u.wr(ADDR_SETT, 8'h01);
		smp(8'h20);
		rdc(ADDR_PTRS, 8'h01);
		rdc(ADDR_TC_L, 8'h00);
		rdc(ADDR_TC_H, 8'h00);
		smp(8'h05);
		rdc(ADDR_PTRS, 8'h01);
		$display("test advance done");
		cmd(CMD_STOP);
		chk({6'h00, running_q, irq_q}, 8'h01);
		rdc(ADDR_OUTS, 8'h80);
		chk({7'h00, irq_q}, 8'h00);
		rdc(ADDR_OUTS, 8'h00);
		smp(8'h20);
		rdc(ADDR_PTRS, 8'h01);
		cmd(CMD_CONT);
		chk({6'h00, running_q, irq_q}, 8'h03);
		rdc(ADDR_PTRS, 8'h00);
		rdc(ADDR_OUTS, 8'h80);
		$display("test stop and continue done");
		host_u.wr(ADDR_SETT, 8'h00);
		cmd(CMD_STOP);
		chk({7'h00, irq_q}, 8'h00);
		rdc(ADDR_OUTS, 8'h00);
		cmd(CMD_CONT);
		host_u.wr(ADDR_DMASK, 8'h00);
		smp(8'h20);
		rdc(ADDR_PTRS, 8'h00);
		host_u.wr(ADDR_DMASK, 8'hff);
		$display("test quiet output and mask done");
		host_u.wr(ADDR_SETT, 8'h04);
		smp(8'h20);
		rdc(ADDR_PTRS, 8'h01);
		smp(8'h40);
		rdc(ADDR_PTRS, 8'h00);
		cmd(CMD_CHOOSE_SWAP_MASK_CMD);
		smp(8'h20);
		smp(8'h40);
		rdc(ADDR_PTRS, 8'h02);
		host_u.wr(ADDR_SETT, 8'h40);
		smp(8'h40);
		rdc(ADDR_PTRS, 8'h00);
		$display("test third limit done");
		// Only x+ is watched through the swap mask from here on.
		host_u.wr(ADDR_SETT, 8'h00);
		host_u.wr(ADDR_SWAP, 8'h80);
		host_u.wr(8'h60, 8'h70);
		host_u.wr(8'h61, 8'h71);
		host_u.wr(8'h62, 8'h65);
		host_u.wr(8'h63, 8'h6f);
		host_u.wr(ADDR_TIM1_L, 8'h02);
		smp(8'h20);
		rdc(ADDR_PTRS, 8'h01);
		smp(8'h20);
		smp(8'h20);
		rdc(ADDR_PTRS, 8'h01);
		rdc(ADDR_TC_L, 8'h02);
		smp(8'h20);
		rdc(ADDR_PTRS, 8'h02);
		$display("test no operation and timer done");
		// A negative limit in signed mode never fires the plus side.
		host_u.wr(ADDR_THR1, 8'hf0);
		host_u.wr(ADDR_SETT, 8'h20);
		smp(8'h20);
		rdc(ADDR_PTRS, 8'h02);
		host_u.wr(ADDR_SETT, 8'h00);
		smp(8'h20);
		rdc(ADDR_PTRS, 8'h03);
		smp(8'he0);
		rdc(ADDR_PTRS, 8'h03);
		smp(8'h20);
		rdc(ADDR_PTRS, 8'h04);
		cmd(CMD_SET_OUTPUTS_COMMAND);
		rdc(ADDR_OUTS, 8'h80);
		$display("test signed limit and zero cross done");
		give_verdict();
	end
endmodule
